// ===== rtl/aeag_pkg.sv
// Package for the array effective address generator: field layouts and modes.
// Assumes a 29-bit effective address and two machine widths, narrow and wide.
package aeag_pkg;

    typedef enum logic [1:0] {
        AEAG_PLANE_BIT,
        AEAG_ROW,
        AEAG_WORD
    } aeag_mode_e;

    localparam int ADDR_W = 29;
    localparam int PLANE_W = 20;
    localparam int ITER_W = 32;
    localparam int MOD_W = 32;

    // Narrow machine: check[28:25], plane[24:5], index[4:0]
    localparam int N_INDEX_W = 5;
    localparam int N_PLANE_LSB = 5;
    localparam int N_CHECK_LSB = 25;
    localparam int N_COMB_BITS = 29;
    localparam int N_PLANE_STEP_BITS = 24;

    // Wide machine: check[28:27], plane[26:7], index[6:1], word[0]
    localparam int W_INDEX_W = 6;
    localparam int W_INDEX_LSB = 1;
    localparam int W_PLANE_LSB = 7;
    localparam int W_CHECK_LSB = 27;
    localparam int W_COMB_BITS = 28;
    localparam int W_PLANE_STEP_BITS = 22;

    localparam logic [ADDR_W-1:0] N_LO_MASK = 29'h0000001F;
    localparam logic [ADDR_W-1:0] N_HI_MASK = 29'h1FFFFFE0;
    localparam logic [ADDR_W-1:0] W_LO_MASK = 29'h0000007E;
    localparam logic [ADDR_W-1:0] W_HI_MASK = 29'h1FFFFF80;
    localparam logic [ADDR_W-1:0] W_WORD_MASK = 29'h00000001;
    localparam logic [ADDR_W-1:0] N_CHECK_MASK = 29'h1E000000;
    localparam logic [ADDR_W-1:0] W_CHECK_MASK = 29'h18000000;

    localparam logic [ADDR_W-1:0] ADDR_RST = 29'h00000000;

endpackage

// ===== rtl/aeag_core.sv
// Effective address generator for plane-and-bit, row and word addressing.
// Assumes all inputs come from sequencer logic on the same clock; the address
// and error are formed combinationally, with a registered copy for the store.
//
// Operation
// - Plane-bit mode: no index-to-plane carry, top carry dropped
// - Narrow split: 4 check, 20 plane, 5 index
// - Wide split: 2 check, 20 plane, 6 index, word
// - Store access with nonzero check bits errors
// - Plane-bit stepping: index wraps, plane steps independently
// - Row mode: index carry enters plane
// - Row and word: 29-bit sum of terms
// - Combined row step: low 29, or 28 shifted
// - Plane-only row step: low 24 or 22 bits
// - Step select picks combined or plane-only term
// - Stepping term only inside loop with request
// - Step direction negative subtracts the term
// - Modifier low 29 bits added when requested
// - Wide row mode clears word field
// - Word mode: word carries to index to plane
// - Narrow word mode behaves as row mode with combined step
// - Word step term: low 29 iteration bits
// - Word mode has no plane-only stepping
// - Store access with plane above limit errors
`timescale 1ns/100ps

module aeag_core (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire aeag_pkg::aeag_mode_e mode,
    input wire logic wide_machine,
    input wire logic [aeag_pkg::PLANE_W-1:0] instr_plane,
    input wire logic [aeag_pkg::W_INDEX_W-1:0] instr_index,
    input wire logic instr_word,
    input wire logic [aeag_pkg::ITER_W-1:0] iteration,
    input wire logic in_loop,
    input wire logic step_request,
    input wire logic step_plane_only,
    input wire logic step_direction_field,
    input wire logic modify_en,
    input wire logic [aeag_pkg::MOD_W-1:0] modifier,
    input wire logic store_access,
    input wire logic [aeag_pkg::PLANE_W-1:0] plane_limit,
    output logic [aeag_pkg::ADDR_W-1:0] eff_addr,
    output logic [aeag_pkg::PLANE_W-1:0] eff_plane,
    output logic [aeag_pkg::W_INDEX_W-1:0] eff_index,
    output logic eff_word,
    output logic addr_error,
    output logic check_error,
    output logic limit_error,
    output logic valid_q,
    output logic [aeag_pkg::ADDR_W-1:0] addr_q,
    output logic error_q
);

    function automatic logic [aeag_pkg::ADDR_W-1:0] addsub(
        input logic [aeag_pkg::ADDR_W-1:0] a,
        input logic [aeag_pkg::ADDR_W-1:0] b,
        input logic neg
    );
        addsub = neg ? a - b : a + b;
    endfunction

    logic [aeag_pkg::ADDR_W-1:0] instr_term;
    logic [aeag_pkg::ADDR_W-1:0] mod_term;
    logic [aeag_pkg::ADDR_W-1:0] comb_step;
    logic [aeag_pkg::ADDR_W-1:0] plane_step;
    logic [aeag_pkg::ADDR_W-1:0] index_step;
    logic [aeag_pkg::ADDR_W-1:0] row_step;
    logic [aeag_pkg::ADDR_W-1:0] lo_mask;
    logic [aeag_pkg::ADDR_W-1:0] hi_mask;
    logic [aeag_pkg::ADDR_W-1:0] check_mask;
    logic [aeag_pkg::ADDR_W-1:0] pb_lo;
    logic [aeag_pkg::ADDR_W-1:0] pb_hi;
    logic [aeag_pkg::ADDR_W-1:0] pb_addr;
    logic [aeag_pkg::ADDR_W-1:0] row_addr;
    logic [aeag_pkg::ADDR_W-1:0] word_addr;
    logic [aeag_pkg::ADDR_W-1:0] sel_addr;
    logic stepping;
    logic neg;
    logic [aeag_pkg::ADDR_W-1:0] addr_d;
    logic error_d;

    // Composite instruction field; wide keeps the word bit at the bottom
    assign instr_term = wide_machine
        ? {2'h0, instr_plane, instr_index, instr_word}
        : {4'h0, instr_plane, instr_index[aeag_pkg::N_INDEX_W-1:0]};

    assign mod_term = modify_en ? modifier[aeag_pkg::ADDR_W-1:0] : aeag_pkg::ADDR_RST;

    assign stepping = in_loop & step_request;
    assign neg = step_direction_field;

    assign comb_step = wide_machine
        ? {iteration[aeag_pkg::W_COMB_BITS-1:0], 1'h0}
        : iteration[aeag_pkg::N_COMB_BITS-1:0];

    // plane-only step aligned to plane lsb
    assign plane_step = wide_machine
        ? {iteration[aeag_pkg::W_PLANE_STEP_BITS-1:0], 7'h00}
        : {iteration[aeag_pkg::N_PLANE_STEP_BITS-1:0], 5'h00};

    assign index_step = wide_machine
        ? {22'h000000, iteration[aeag_pkg::W_INDEX_W-1:0], 1'h0}
        : {24'h000000, iteration[aeag_pkg::N_INDEX_W-1:0]};

    assign row_step = !stepping ? aeag_pkg::ADDR_RST : (step_plane_only ? plane_step : comb_step);

    assign lo_mask = wide_machine ? aeag_pkg::W_LO_MASK : aeag_pkg::N_LO_MASK;
    assign hi_mask = wide_machine ? aeag_pkg::W_HI_MASK : aeag_pkg::N_HI_MASK;
    assign check_mask = wide_machine ? aeag_pkg::W_CHECK_MASK : aeag_pkg::N_CHECK_MASK;

    // index and plane parts summed apart, no carry between them
    // index wraps within its width while plane steps on its own
    assign pb_lo = addsub(instr_term & lo_mask, stepping ? index_step : aeag_pkg::ADDR_RST, neg)
        + (mod_term & lo_mask);
    assign pb_hi = addsub(instr_term & hi_mask, stepping ? plane_step : aeag_pkg::ADDR_RST, neg)
        + (mod_term & hi_mask);
    // word bit disregarded in plane-bit mode
    assign pb_addr = (pb_lo & lo_mask) | (pb_hi & hi_mask);

    // index carry ripples into plane through one 29-bit add
    // sum of instruction, step and modifier, top carry dropped
    // wide row mode clears the word field
    assign row_addr = (addsub(instr_term, row_step, neg) + mod_term)
        & ~(wide_machine ? aeag_pkg::W_WORD_MASK : aeag_pkg::ADDR_RST);

    // word to index to plane carry in one add
    // combined step from low 29 iteration bits
    // step select ignored, no plane-only stepping
    // narrow word mode equals narrow row mode with combined step
    assign word_addr = addsub(instr_term, stepping ? iteration[aeag_pkg::ADDR_W-1:0] : aeag_pkg::ADDR_RST,
        neg) + mod_term;

    always_comb begin
        sel_addr = aeag_pkg::ADDR_RST;
        unique case (mode)
            aeag_pkg::AEAG_PLANE_BIT: sel_addr = pb_addr;
            aeag_pkg::AEAG_ROW: sel_addr = row_addr;
            aeag_pkg::AEAG_WORD: sel_addr = word_addr;
            default: sel_addr = aeag_pkg::ADDR_RST;
        endcase
    end

    // address is available in the cycle the terms arrive
    assign eff_addr = sel_addr;

    assign eff_plane = wide_machine
        ? sel_addr[aeag_pkg::W_PLANE_LSB +: aeag_pkg::PLANE_W]
        : sel_addr[aeag_pkg::N_PLANE_LSB +: aeag_pkg::PLANE_W];
    assign eff_index = wide_machine
        ? sel_addr[aeag_pkg::W_INDEX_LSB +: aeag_pkg::W_INDEX_W]
        : {1'h0, sel_addr[aeag_pkg::N_INDEX_W-1:0]};
    assign eff_word = wide_machine & sel_addr[0];

    // nonzero check bits on a store access
    assign check_error = store_access & ((sel_addr & check_mask) != aeag_pkg::ADDR_RST);
    assign limit_error = store_access & (eff_plane > plane_limit);
    // one error output for both failures
    assign addr_error = check_error | limit_error;

    assign addr_d = req_valid ? sel_addr : addr_q;
    assign error_d = req_valid & addr_error;

    // Registered copy for the store access stage
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            valid_q <= 1'h0;
            addr_q <= aeag_pkg::ADDR_RST;
            error_q <= 1'h0;
        end else begin
            valid_q <= req_valid;
            addr_q <= addr_d;
            error_q <= error_d;
        end
    end

    chk_pb_no_carry: assert property (
        @(posedge clock) disable iff (!rst_n)
        (mode == aeag_pkg::AEAG_PLANE_BIT && !wide_machine && !modify_en && stepping && !neg
            && iteration[aeag_pkg::N_INDEX_W-1:0] == 5'h01 && iteration[23:0] == 24'h000001
            && instr_index[4:0] == 5'h1F)
        |-> (eff_index == 6'h00 && eff_plane == instr_plane + 20'h00001))
        else $error("plane-bit index carry leaked into plane");

    chk_narrow_split: assert property (
        @(posedge clock) disable iff (!rst_n)
        !wide_machine |-> (eff_plane == eff_addr[24:5] && eff_index == {1'h0, eff_addr[4:0]} && !eff_word))
        else $error("narrow field split wrong");

    chk_wide_split: assert property (
        @(posedge clock) disable iff (!rst_n)
        (wide_machine && mode == aeag_pkg::AEAG_PLANE_BIT) |-> (!eff_word && eff_plane == eff_addr[26:7]))
        else $error("wide plane-bit split wrong");

    chk_check_error: assert property (
        @(posedge clock) disable iff (!rst_n)
        (store_access && (wide_machine ? eff_addr[28:27] != 2'h0 : eff_addr[28:25] != 4'h0)) |-> addr_error)
        else $error("check bits nonzero without error");

    chk_row_carry: assert property (
        @(posedge clock) disable iff (!rst_n)
        (mode == aeag_pkg::AEAG_ROW && !wide_machine && !modify_en && stepping && !neg && !step_plane_only
            && iteration[28:0] == 29'h00000001 && instr_index[4:0] == 5'h1F && instr_plane != 20'hFFFFF)
        |-> (eff_index == 6'h00 && eff_plane == instr_plane + 20'h00001))
        else $error("row carry did not reach plane");

    chk_step_gate: assert property (
        @(posedge clock) disable iff (!rst_n)
        (!stepping && !modify_en && mode != aeag_pkg::AEAG_PLANE_BIT && !wide_machine)
        |-> eff_addr == {4'h0, instr_plane, instr_index[4:0]})
        else $error("address changed without step or modifier");

    chk_neg_step: assert property (
        @(posedge clock) disable iff (!rst_n)
        (mode == aeag_pkg::AEAG_WORD && stepping && neg && !modify_en)
        |-> eff_addr + iteration[28:0] == instr_term)
        else $error("negative step not subtracted");

    chk_mod_add: assert property (
        @(posedge clock) disable iff (!rst_n)
        (mode == aeag_pkg::AEAG_WORD && !stepping && modify_en)
        |-> eff_addr == instr_term + modifier[28:0])
        else $error("modifier not added");

    chk_row_word: assert property (
        @(posedge clock) disable iff (!rst_n)
        (mode == aeag_pkg::AEAG_ROW && wide_machine) |-> !eff_word)
        else $error("row mode used word field");

    chk_limit_error: assert property (
        @(posedge clock) disable iff (!rst_n)
        (store_access && eff_plane > plane_limit) |-> addr_error)
        else $error("plane above limit without error");

    chk_error_combine: assert property (
        @(posedge clock) disable iff (!rst_n)
        !store_access |-> !addr_error ##1 (error_q == 1'h0))
        else $error("error without store access");

    chk_reg_copy: assert property (
        @(posedge clock) disable iff (!rst_n)
        req_valid |=> (valid_q && addr_q == $past(eff_addr) && error_q == $past(addr_error)))
        else $error("registered copy does not follow");

    chk_pb_narrow_step: assert property (
        @(posedge clock) disable iff (!rst_n)
        (mode == aeag_pkg::AEAG_PLANE_BIT && !wide_machine && stepping && !neg && !modify_en)
        |-> (eff_index[4:0] == instr_index[4:0] + iteration[4:0] && eff_plane == instr_plane + iteration[19:0]))
        else $error("narrow plane-bit stepping wrong");

    chk_pb_wide_step: assert property (
        @(posedge clock) disable iff (!rst_n)
        (mode == aeag_pkg::AEAG_PLANE_BIT && wide_machine && stepping && !neg && !modify_en)
        |-> (eff_index == instr_index + iteration[5:0] && eff_plane == instr_plane + iteration[19:0]
            && !eff_word))
        else $error("wide plane-bit stepping wrong");

    chk_row_plane_step: assert property (
        @(posedge clock) disable iff (!rst_n)
        (mode == aeag_pkg::AEAG_ROW && stepping && step_plane_only && !neg && !modify_en)
        |-> (eff_plane == instr_plane + iteration[19:0]
            && eff_index == (wide_machine ? instr_index : {1'h0, instr_index[4:0]})))
        else $error("plane-only row step wrong");

    chk_row_comb_wide: assert property (
        @(posedge clock) disable iff (!rst_n)
        (mode == aeag_pkg::AEAG_ROW && wide_machine && stepping && neg && !step_plane_only && !modify_en)
        |-> eff_addr + {iteration[27:0], 1'h0} == {2'h0, instr_plane, instr_index, 1'h0})
        else $error("wide combined row step wrong");

    chk_word_step: assert property (
        @(posedge clock) disable iff (!rst_n)
        (mode == aeag_pkg::AEAG_WORD && stepping && !neg && !modify_en)
        |-> eff_addr == (wide_machine ? {2'h0, instr_plane, instr_index, instr_word}
            : {4'h0, instr_plane, instr_index[4:0]}) + iteration[28:0])
        else $error("word step wrong");

    chk_narrow_word_row: assert property (
        @(posedge clock) disable iff (!rst_n)
        (mode == aeag_pkg::AEAG_WORD && !wide_machine && !neg)
        |-> eff_addr == {4'h0, instr_plane, instr_index[4:0]} + (stepping ? iteration[28:0] : 29'h0)
            + (modify_en ? modifier[28:0] : 29'h0))
        else $error("narrow word mode differs from row mode");

    chk_reg_hold: assert property (
        @(posedge clock) disable iff (!rst_n)
        !req_valid |=> (!valid_q && !error_q && addr_q == $past(addr_q)))
        else $error("registered copy changed without request");

    chk_limit_clear: assert property (
        @(posedge clock) disable iff (!rst_n)
        (store_access && eff_plane <= plane_limit
            && (wide_machine ? eff_addr[28:27] == 2'h0 : eff_addr[28:25] == 4'h0)) |-> !addr_error)
        else $error("error raised with address in range");

endmodule

// ===== dv/aeag_store_model.sv
// Store-side model: records each address handed over by the registered copy.
// Assumes the store takes an address only in the cycle valid_q stands high.
`timescale 1ns/100ps
module aeag_store_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic valid_q,
    input wire logic [28:0] addr_q,
    input wire logic error_q,
    output logic [28:0] last_addr_q,
    output logic last_err_q,
    output logic [7:0] count_q
);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count_q <= 8'h00;
            last_addr_q <= 29'h0;
            last_err_q <= 1'b0;
        end else if (valid_q) begin
            count_q <= count_q + 8'h01;
            last_addr_q <= addr_q;
            last_err_q <= error_q;
        end
    end
endmodule

// ===== dv/array_effective_address_gen_tb.sv
// Testbench for the address generator: mode sums, field splits, errors, registered copy.
// Assumes one 100 MHz clock; the store model records what the registered copy hands over.
`timescale 1ns/100ps
module array_effective_address_gen_tb;
    localparam aeag_pkg::aeag_mode_e PB = aeag_pkg::AEAG_PLANE_BIT;
    localparam aeag_pkg::aeag_mode_e RW = aeag_pkg::AEAG_ROW;
    localparam aeag_pkg::aeag_mode_e WD = aeag_pkg::AEAG_WORD;
    localparam aeag_pkg::aeag_mode_e BAD = aeag_pkg::aeag_mode_e'(2'h3);
    logic clock = 0;
    logic rst_n = 0;
    aeag_pkg::aeag_mode_e mode = PB;
    logic req_valid = 0, wide_machine = 0, instr_word = 0, in_loop = 0, step_request = 0;
    logic step_plane_only = 0, step_direction_field = 0, modify_en = 0, store_access = 0;
    logic [19:0] instr_plane = '0, plane_limit = '0, eff_plane, p;
    logic [5:0] instr_index = '0, eff_index, x;
    logic [31:0] iteration = '0, modifier = '0;
    logic [28:0] eff_addr, addr_q, last_addr_q, r, a1, a2;
    logic eff_word, addr_error, check_error, limit_error, valid_q, error_q, last_err_q, e, e1, e2;
    logic [7:0] count_q;
    int num_errors = 0, num_checks = 0;
    always #5 clock = ~clock;
    aeag_core aeag_core_i (.clock, .rst_n, .req_valid, .mode, .wide_machine, .instr_plane, .instr_index,
        .instr_word, .iteration, .in_loop, .step_request, .step_plane_only, .step_direction_field, .modify_en,
        .modifier, .store_access, .plane_limit, .eff_addr, .eff_plane, .eff_index, .eff_word, .addr_error,
        .check_error, .limit_error, .valid_q, .addr_q, .error_q);
    aeag_store_model aeag_store_model_i (.clock, .rst_n, .valid_q, .addr_q, .error_q, .last_addr_q,
        .last_err_q, .count_q);
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Drives one request, works out the address from the mode rules and compares
    task automatic apply(input aeag_pkg::aeag_mode_e m, input logic w, input logic [19:0] pl,
        input logic [5:0] ix, input logic wd, input logic [31:0] it, input logic [6:0] f, input logic [31:0] md);
        logic [28:0] ins, lo, hi, m29, s_hi, s_lo, s;
        @(posedge clock);
        #1;
        mode = m;
        {wide_machine, instr_plane, instr_index, instr_word, iteration, modifier} = {w, pl, ix, wd, it, md};
        {req_valid, store_access, in_loop, step_request, step_plane_only, step_direction_field, modify_en} = f;
        m29 = modify_en ? md[28:0] : 29'h0;
        ins = w ? {2'h0, pl, ix, wd} : {4'h0, pl, ix[4:0]};
        lo = w ? aeag_pkg::W_LO_MASK : aeag_pkg::N_LO_MASK;
        hi = w ? aeag_pkg::W_HI_MASK : aeag_pkg::N_HI_MASK;
        s_hi = w ? {it[21:0], 7'h00} : {it[23:0], 5'h00};
        s_lo = (w ? {it[27:0], 1'b0} : it[28:0]) & lo;
        s = (m == WD) ? it[28:0] : (step_plane_only ? s_hi : (w ? {it[27:0], 1'b0} : it[28:0]));
        if (!(in_loop && step_request)) {s, s_hi, s_lo} = '0;
        if (step_direction_field) {s, s_hi, s_lo} = {-s, -s_hi, -s_lo};
        if (m == PB) r = ((ins & lo) + s_lo + (m29 & lo)) & lo | ((ins & hi) + s_hi + (m29 & hi)) & hi;
        else r = ins + s + m29;
        if (m == BAD) r = 29'h0;
        if (w && m == RW) r[0] = 1'b0;
        p = w ? r[26:7] : r[24:5];
        x = w ? r[6:1] : {1'b0, r[4:0]};
        e = store_access && (p > plane_limit || |(r & (w ? aeag_pkg::W_CHECK_MASK : aeag_pkg::N_CHECK_MASK)));
        #1;
        chk(eff_addr, r);
        chk({eff_plane, eff_index, eff_word}, {p, x, w & r[0]});
        chk(addr_error, e);
    endtask
    task automatic t_plane_bit();
        for (int w = 0; w < 2; w++) begin
            for (int k = 1; k < 4; k++) begin
                apply(PB, w[0], w ? 20'h41 : 20'h3C, w ? 6'h3E : 6'h1D, 1'b0, k, 7'h18, '0);
                chk(eff_plane, (w ? 32'h41 : 32'h3C) + k);
                chk(eff_index, ((w ? 32'h3E : 32'h1D) + k) % (w ? 32'h40 : 32'h20));
            end
        end
        apply(PB, 1'b0, 20'hFFFFF, 6'h1F, 1'b0, 32'h1, 7'h18, '0);
        chk({eff_plane, eff_index}, {20'h00000, 6'h00});
        apply(PB, 1'b0, 20'hFFFFF, 6'h1F, 1'b0, 32'h1, 7'h19, 32'h1E00_0000);
        chk(eff_addr, 29'h0000000);
        apply(PB, 1'b0, 20'h00010, 6'h00, 1'b0, 32'h1, 7'h1B, 32'hE000_0021);
        chk({eff_plane, eff_index}, {20'h00010, 6'h00});
        apply(PB, 1'b1, 20'h3C, 6'h1D, 1'b0, 32'h5, 7'h08, '0);
        chk(eff_plane, 20'h3C);
    endtask
    task automatic t_row();
        apply(RW, 1'b0, 20'h0A, 6'h1F, 1'b0, 32'h1, 7'h18, '0);
        chk({eff_plane, eff_index}, {20'h0B, 6'h00});
        for (int k = 1; k < 4; k++) apply(RW, 1'b1, 20'h32, 6'h02, 1'b0, k, 7'h1A, '0);
        chk({eff_plane, eff_index}, {20'h31, 6'h3F});
        apply(RW, 1'b1, 20'h32, 6'h02, 1'b1, 32'h3, 7'h1C, '0);
        chk({eff_plane, eff_index, eff_word}, {20'h35, 6'h02, 1'b0});
        apply(RW, 1'b0, 20'h05, 6'h03, 1'b0, 32'h2, 7'h1C, '0);
        chk({eff_plane, eff_index}, {20'h07, 6'h03});
        apply(RW, 1'b0, 20'h05, 6'h03, 1'b0, 32'h2, 7'h11, 32'hFFFF_FFFF);
        chk({eff_plane, eff_index}, {20'h05, 6'h02});
    endtask
    task automatic t_word();
        for (int k = 1; k < 4; k++) apply(WD, 1'b1, 20'h26, 6'h3E, 1'b1, k, 7'h1C, '0);
        chk({eff_plane, eff_index, eff_word}, {20'h27, 6'h00, 1'b0});
        apply(WD, 1'b0, 20'h0A, 6'h1F, 1'b0, 32'h1, 7'h18, '0);
        chk({eff_plane, eff_index}, {20'h0B, 6'h00});
        apply(WD, 1'b1, 20'h27, 6'h00, 1'b0, 32'h1, 7'h1A, '0);
        chk({eff_plane, eff_index, eff_word}, {20'h26, 6'h3F, 1'b1});
        apply(WD, 1'b1, 20'h26, 6'h3F, 1'b1, 32'h0, 7'h01, 32'h0000_0001);
        chk({eff_plane, eff_index, eff_word}, {20'h27, 6'h00, 1'b0});
    endtask
    task automatic t_errors();
        apply(RW, 1'b0, 20'h64, 6'h00, 1'b0, 32'h0, 7'h20, '0);
        chk({check_error, limit_error}, 2'h0);
        apply(RW, 1'b0, 20'h65, 6'h00, 1'b0, 32'h0, 7'h20, '0);
        chk({check_error, limit_error}, 2'h1);
        apply(RW, 1'b0, 20'h01, 6'h00, 1'b0, 32'h0, 7'h21, 32'h0200_0000);
        chk({check_error, limit_error}, 2'h2);
        apply(RW, 1'b1, 20'h01, 6'h00, 1'b0, 32'h0, 7'h21, 32'h0800_0000);
        chk({check_error, limit_error}, 2'h2);
        apply(RW, 1'b1, 20'h01, 6'h00, 1'b0, 32'h0, 7'h01, 32'h0800_0000);
        chk({check_error, limit_error}, 2'h0);
        apply(BAD, 1'b0, 20'h05, 6'h03, 1'b0, 32'h2, 7'h21, 32'h0200_0000);
        chk({eff_addr, check_error, limit_error}, 31'h0);
    endtask
    task automatic t_regs();
        apply(RW, 1'b0, 20'h65, 6'h00, 1'b0, 32'h0, 7'h60, '0);
        {a1, e1} = {r, e};
        apply(RW, 1'b0, 20'h12, 6'h03, 1'b0, 32'h0, 7'h60, '0);
        {a2, e2} = {r, e};
        chk({valid_q, addr_q, error_q}, {1'b1, a1, e1});
        apply(RW, 1'b0, 20'h13, 6'h03, 1'b0, 32'h0, 7'h20, '0);
        chk({valid_q, addr_q, error_q}, {1'b1, a2, e2});
        apply(RW, 1'b0, 20'h65, 6'h03, 1'b0, 32'h0, 7'h20, '0);
        chk({valid_q, addr_q, error_q}, {1'b0, a2, 1'b0});
        chk({count_q, last_addr_q, last_err_q}, {8'h02, a2, e2});
    endtask
    task automatic tally_and_finish();
        if (num_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        plane_limit = 20'h64;
        repeat (20) @(posedge clock);
        #1;
        chk({valid_q, addr_q, error_q}, '0);
        rst_n = 1;
        t_plane_bit();
        t_row();
        t_word();
        t_errors();
        t_regs();
        tally_and_finish();
    end
    initial begin
        #20000;
        num_errors++;
        tally_and_finish();
    end
endmodule
